//--- rtl/dbc_top.sv
// three bus comparators with banked register window and axi4-lite slave
// assumes cpu bus and execution strobes synchronous to aclk
//
// Local design decision: the AXI4-Lite register port.
module dbc_top #(
	parameter int ADDR_W = 10
) (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic [2:0]           s_axi_awprot,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [ADDR_W-1:0]    s_axi_araddr,
	input  wire logic [2:0]           s_axi_arprot,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire dbc_pkg::dbc_cpu_bus_t cpu_bus,
	input  wire dbc_pkg::dbc_exec_t    cpu_exec,
	output logic [2:0]                match_pulse,
	output logic                      session_end,
	output logic                      trace_stop,
	output logic                      break_req,
	output logic                      armed,
	output logic                      irq
);

	typedef struct packed {
		logic [2:0][7:0]   ctl;
		logic [2:0][17:0]  adr;
		logic [15:0]       dat;
		logic [15:0]       msk;
		logic [1:0]        win;
		logic              arm;
		logic              bkpt_en;
		logic [2:0]        tag_pend;
		logic [2:0]        match;
		logic              sess_end;
		logic              bkpt;
		logic [3:0]        sts;
		logic [3:0]        ien;
		logic              aw_held;
		logic [ADDR_W-1:0] aw_addr;
		logic              w_held;
		logic [7:0]        w_byte;
		logic              w_lane0;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [7:0]        rdata;
		logic [1:0]        rresp;
	} dbc_state_t;

	dbc_state_t s;
	dbc_state_t next_s;

	function automatic dbc_pkg::dbc_reg_t dbc_decode(input logic [ADDR_W-1:0] a);
		logic [7:0] idx;
		idx = 8'(a[ADDR_W-1:2]);
		unique case (idx)
			dbc_pkg::IDX_MAIN: return dbc_pkg::DBC_R_MAIN;
			dbc_pkg::IDX_CTL:  return dbc_pkg::DBC_R_CTL;
			dbc_pkg::IDX_AH:   return dbc_pkg::DBC_R_AH;
			dbc_pkg::IDX_AM:   return dbc_pkg::DBC_R_AM;
			dbc_pkg::IDX_AL:   return dbc_pkg::DBC_R_AL;
			dbc_pkg::IDX_DH:   return dbc_pkg::DBC_R_DH;
			dbc_pkg::IDX_DL:   return dbc_pkg::DBC_R_DL;
			dbc_pkg::IDX_MH:   return dbc_pkg::DBC_R_MH;
			dbc_pkg::IDX_ML:   return dbc_pkg::DBC_R_ML;
			dbc_pkg::IDX_STS:  return dbc_pkg::DBC_R_STS;
			dbc_pkg::IDX_IEN:  return dbc_pkg::DBC_R_IEN;
			dbc_pkg::IDX_ICLR: return dbc_pkg::DBC_R_ICLR;
			default:           return dbc_pkg::DBC_R_NONE;
		endcase
	endfunction

	// per-comparator match terms
	logic [2:0] hit_addr;
	logic [2:0] hit_exec;
	logic [2:0] forced;
	logic [2:0] tag_set;
	logic [2:0] tag_fire;
	logic       data_ok;

	// data compare only comparator A owns
	always_comb begin
		data_ok = ((cpu_bus.data ^ s.dat) & s.msk) == 16'h0000;
		if (s.ctl[0][dbc_pkg::CTL_DATA_NE]) begin
			data_ok = !data_ok;
		end
	end

	generate
		for (genvar i = 0; i < 3; i++) begin : g_cmp
			logic size_ok;
			logic dir_ok;
			logic dat_ok;
			logic on;
			logic tag;
			assign on = s.ctl[i][dbc_pkg::CTL_ON] && s.arm;
			assign tag = s.ctl[i][dbc_pkg::CTL_TAG];
			assign hit_addr[i] = cpu_bus.addr == s.adr[i];
			assign hit_exec[i] = cpu_exec.addr == s.adr[i];
			// comparator C has no size bits; its stored bits are forced zero
			assign size_ok = !s.ctl[i][dbc_pkg::CTL_SIZE_CHK]
				|| (cpu_bus.byte_acc == s.ctl[i][dbc_pkg::CTL_SIZE_SEL]);
			assign dir_ok = !s.ctl[i][dbc_pkg::CTL_DIR_CHK]
				|| (cpu_bus.read == s.ctl[i][dbc_pkg::CTL_RW]);
			assign dat_ok = (i == 0) ? data_ok : 1'b1;
			// tagging bypasses size, direction and data checks
			assign forced[i] = on && !tag && cpu_bus.valid && hit_addr[i]
				&& size_ok && dir_ok && dat_ok;
			assign tag_set[i] = on && tag && cpu_bus.valid && hit_addr[i];
			assign tag_fire[i] = on && tag && cpu_exec.valid && hit_exec[i]
				&& (s.tag_pend[i] || tag_set[i]);
		end
	endgenerate

	logic [2:0]            hit;
	logic                  stop;
	dbc_pkg::dbc_reg_t     wsel;
	dbc_pkg::dbc_reg_t     rsel;
	logic                  do_wr;
	logic                  do_rd;
	logic                  cmp_vis;
	logic                  wr_cmp;
	logic [1:0]            wi;
	logic [7:0]            wb;
	logic [7:0]            rb;
	logic [1:0]            ri;
	localparam int STS_W_L = dbc_pkg::STS_W;

	logic [STS_W_L-1:0]    ev;
	logic [STS_W_L-1:0]    clr;

	always_comb begin
		next_s = s;
		hit = forced | tag_fire;
		stop = 1'b0;
		for (int i = 0; i < 3; i++) begin
			if (hit[i] && s.ctl[i][dbc_pkg::CTL_STOP]) begin
				stop = 1'b1;
			end
		end

		// one-cycle event outputs
		next_s.match = hit;
		next_s.sess_end = stop;
		next_s.bkpt = stop && s.bkpt_en;
		next_s.tag_pend = (s.tag_pend | tag_set) & ~tag_fire;
		if (!s.arm) begin
			next_s.tag_pend = 3'h0;
		end

		// axi write path: address and data taken in either order
		wsel = dbc_decode(s.aw_addr);
		wi = s.win;
		wb = s.w_byte;
		cmp_vis = s.win != dbc_pkg::WIN_NONE;
		if (s_axi_awvalid && !s.aw_held) begin
			next_s.aw_held = 1'b1;
			next_s.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s.w_held) begin
			next_s.w_held = 1'b1;
			next_s.w_byte = s_axi_wdata[7:0];
			next_s.w_lane0 = s_axi_wstrb[0];
		end
		do_wr = s.aw_held && s.w_held && !s.bvalid;
		wr_cmp = do_wr && s.w_lane0 && cmp_vis && !s.arm;
		clr = '0;
		if (do_wr) begin
			next_s.aw_held = 1'b0;
			next_s.w_held = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = (wsel == dbc_pkg::DBC_R_NONE) ? dbc_pkg::RESP_ERR : dbc_pkg::RESP_OK;
			if (s.w_lane0) begin
				unique case (wsel)
					dbc_pkg::DBC_R_MAIN: begin
						next_s.arm = wb[dbc_pkg::MAIN_ARM];
						next_s.bkpt_en = wb[dbc_pkg::MAIN_BRKEN];
						next_s.win = wb[dbc_pkg::MAIN_WIN +: 2];
					end
					dbc_pkg::DBC_R_IEN: begin
						next_s.ien = wb[STS_W_L-1:0];
					end
					dbc_pkg::DBC_R_ICLR: begin
						clr = wb[STS_W_L-1:0];
					end
					default: begin
					end
				endcase
			end
			if (wr_cmp) begin
				unique case (wsel)
					dbc_pkg::DBC_R_CTL: begin
						next_s.ctl[wi] = wb & dbc_pkg::CTL_MASK[wi];
					end
					dbc_pkg::DBC_R_AH: begin
						next_s.adr[wi][17:16] = wb[1:0];
					end
					dbc_pkg::DBC_R_AM: begin
						next_s.adr[wi][15:8] = wb;
					end
					dbc_pkg::DBC_R_AL: begin
						next_s.adr[wi][7:0] = wb;
					end
					default: begin
					end
				endcase
				// data bytes only exist behind comparator A
				if (wi == 2'h0) begin
					unique case (wsel)
						dbc_pkg::DBC_R_DH: next_s.dat[15:8] = wb;
						dbc_pkg::DBC_R_DL: next_s.dat[7:0] = wb;
						dbc_pkg::DBC_R_MH: next_s.msk[15:8] = wb;
						dbc_pkg::DBC_R_ML: next_s.msk[7:0] = wb;
						default: begin
						end
					endcase
				end
			end
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end

		// hardware disarm wins over a same-cycle software arm
		if (stop) begin
			next_s.arm = 1'b0;
		end

		// sticky status; a new event wins over its clear
		ev = {stop, hit};
		next_s.sts = (s.sts & ~clr) | ev;

		// axi read path: one read at a time, answered next cycle
		rsel = dbc_decode(s_axi_araddr);
		ri = s.win;
		do_rd = s_axi_arvalid && !s.rvalid;
		rb = 8'h00;
		unique case (rsel)
			dbc_pkg::DBC_R_MAIN: begin
				rb[dbc_pkg::MAIN_ARM] = s.arm;
				rb[dbc_pkg::MAIN_BRKEN] = s.bkpt_en;
				rb[dbc_pkg::MAIN_WIN +: 2] = s.win;
			end
			dbc_pkg::DBC_R_CTL: rb = cmp_vis ? s.ctl[ri] : 8'h00;
			dbc_pkg::DBC_R_AH: rb = cmp_vis ? {6'h00, s.adr[ri][17:16]} : 8'h00;
			dbc_pkg::DBC_R_AM: rb = cmp_vis ? s.adr[ri][15:8] : 8'h00;
			dbc_pkg::DBC_R_AL: rb = cmp_vis ? s.adr[ri][7:0] : 8'h00;
			dbc_pkg::DBC_R_DH: rb = (ri == 2'h0) ? s.dat[15:8] : 8'h00;
			dbc_pkg::DBC_R_DL: rb = (ri == 2'h0) ? s.dat[7:0] : 8'h00;
			dbc_pkg::DBC_R_MH: rb = (ri == 2'h0) ? s.msk[15:8] : 8'h00;
			dbc_pkg::DBC_R_ML: rb = (ri == 2'h0) ? s.msk[7:0] : 8'h00;
			dbc_pkg::DBC_R_STS: rb = {4'h0, s.sts};
			dbc_pkg::DBC_R_IEN: rb = {4'h0, s.ien};
			default: rb = 8'h00;
		endcase
		if (do_rd) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = rb;
			next_s.rresp = (rsel == dbc_pkg::DBC_R_NONE) ? dbc_pkg::RESP_ERR : dbc_pkg::RESP_OK;
		end else if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.ctl <= {3{dbc_pkg::RST_CTL}};
			s.adr <= {3{dbc_pkg::RST_ADDR}};
			s.dat <= dbc_pkg::RST_DATA;
			s.msk <= dbc_pkg::RST_DATA;
		end else begin
			s <= next_s;
		end
	end

	// each write channel stays open until its own half of a write is held
	assign s_axi_awready = !s.aw_held;
	assign s_axi_wready = !s.w_held;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = {24'h000000, s.rdata};
	assign s_axi_rresp = s.rresp;

	assign match_pulse = s.match;
	assign session_end = s.sess_end;
	assign trace_stop = s.sess_end;
	assign break_req = s.bkpt;
	assign armed = s.arm;
	assign irq = |(s.sts & s.ien);

endmodule

//--- rtl/dbc_pkg.sv
// constants, field layouts and carrier types of the debug bus comparators
// assumes one clock domain; monitored cpu bus sampled on the same clock
package dbc_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_MAIN   = 8'h20;
	localparam logic [7:0] IDX_CTL    = 8'h28;
	localparam logic [7:0] IDX_AH     = 8'h29;
	localparam logic [7:0] IDX_AM     = 8'h2A;
	localparam logic [7:0] IDX_AL     = 8'h2B;
	localparam logic [7:0] IDX_DH     = 8'h2C;
	localparam logic [7:0] IDX_DL     = 8'h2D;
	localparam logic [7:0] IDX_MH     = 8'h2E;
	localparam logic [7:0] IDX_ML     = 8'h2F;
	localparam logic [7:0] IDX_STS    = 8'h30;
	localparam logic [7:0] IDX_IEN    = 8'h31;
	localparam logic [7:0] IDX_ICLR   = 8'h32;

	// main control fields
	localparam int MAIN_ARM   = 7;
	localparam int MAIN_BRKEN = 4;
	localparam int MAIN_WIN   = 0;

	// comparator control fields
	localparam int CTL_SIZE_CHK = 7;
	localparam int CTL_SIZE_SEL = 6;
	localparam int CTL_TAG      = 5;
	localparam int CTL_STOP     = 4;
	localparam int CTL_RW       = 3;
	localparam int CTL_DIR_CHK  = 2;
	localparam int CTL_DATA_NE  = 1;
	localparam int CTL_ON       = 0;

	// implemented control bits of A, B, C
	localparam logic [2:0][7:0] CTL_MASK = {8'h3D, 8'hFD, 8'hFF};
	localparam logic [7:0]      AH_MASK  = 8'h03;

	localparam logic [1:0] WIN_NONE = 2'h3;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	// reset values
	localparam logic [7:0]  RST_CTL  = 8'h00;
	localparam logic [17:0] RST_ADDR = 18'h00000;
	localparam logic [15:0] RST_DATA = 16'h0000;

	// status bits: match A, B, C, session end
	localparam int STS_W   = 4;
	localparam int STS_END = 3;

	typedef enum logic [3:0] {
		DBC_R_NONE, DBC_R_MAIN, DBC_R_CTL, DBC_R_AH, DBC_R_AM, DBC_R_AL,
		DBC_R_DH, DBC_R_DL, DBC_R_MH, DBC_R_ML, DBC_R_STS, DBC_R_IEN, DBC_R_ICLR
	} dbc_reg_t;

	typedef struct packed {
		logic        valid;
		logic [17:0] addr;
		logic [15:0] data;
		logic        read;
		logic        byte_acc;
	} dbc_cpu_bus_t;

	typedef struct packed {
		logic        valid;
		logic [17:0] addr;
	} dbc_exec_t;

endpackage

//--- tb/dbc_asserts.sv
// checker on the ports of the debug bus comparator top
// assumes one clock, synchronous active-low reset, bound at the foot
module dbc_asserts (
	input wire logic                  aclk,
	input wire logic                  aresetn,
	input wire logic                  s_axi_arvalid,
	input wire logic                  s_axi_arready,
	input wire logic                  s_axi_rvalid,
	input wire logic                  s_axi_rready,
	input wire logic [31:0]           s_axi_rdata,
	input wire dbc_pkg::dbc_cpu_bus_t cpu_bus,
	input wire dbc_pkg::dbc_exec_t    cpu_exec,
	input wire logic [2:0]            match_pulse,
	input wire logic                  session_end,
	input wire logic                  trace_stop,
	input wire logic                  break_req,
	input wire logic                  armed
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dcb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_ar_taken; s_axi_arvalid && s_axi_arready; endsequence
	sequence s_r_stall; s_axi_rvalid && !s_axi_rready; endsequence
	property p_read_answer; s_ar_taken |=> s_axi_rvalid; endproperty
	a_read_answer: assert property (p_read_answer) else $error("read answer missing");
	property p_read_hold; s_r_stall |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_read_hold: assert property (p_read_hold) else $error("read data not held");
	property p_read_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
	a_read_upper: assert property (p_read_upper) else $error("upper read bits set");
	// a disarm at edge t may still show the pulse launched at t
	property p_quiet_disarmed; !armed |=> match_pulse == 3'h0; endproperty
	a_quiet_disarmed: assert property (p_quiet_disarmed) else $error("match while disarmed");
	property p_cause; match_pulse != 3'h0 |-> $past(cpu_bus.valid) || $past(cpu_exec.valid); endproperty
	a_cause: assert property (p_cause) else $error("match without bus cycle");
	property p_end_pair; session_end |-> trace_stop && !armed && match_pulse != 3'h0; endproperty
	a_end_pair: assert property (p_end_pair) else $error("session end incomplete");
	property p_break_in_end; break_req |-> session_end; endproperty
	a_break_in_end: assert property (p_break_in_end) else $error("break outside session end");
	property p_end_single; session_end |=> !session_end; endproperty
	a_end_single: assert property (p_end_single) else $error("session end too long");
endmodule

bind dbc_top dbc_asserts u_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .cpu_bus, .cpu_exec, .match_pulse, .session_end, .trace_stop, .break_req, .armed);

//--- tb/dbc_cpu_model.sv
// cpu bus model: monitored accesses and execution strobes
// assumes its tasks are entered at a rising edge of aclk
module dbc_cpu_model (
	input wire logic              aclk,
	output dbc_pkg::dbc_cpu_bus_t cpu_bus,
	output dbc_pkg::dbc_exec_t    cpu_exec
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cpu_bus = '0;
		cpu_exec = '0;
	end
	// released lines show inverted values so stale data cannot match
	task automatic acc(input logic [17:0] a, input logic rd, input logic sz);
		cpu_bus <= '{1'b1, a, 16'hA5C3, rd, sz};
		@(posedge aclk);
		cpu_bus <= '{1'b0, ~a, 16'h5A3C, ~rd, ~sz};
	endtask
	task automatic ex(input logic [17:0] a);
		cpu_exec <= '{1'b1, a};
		@(posedge aclk);
		cpu_exec <= '{1'b0, ~a};
	endtask
endmodule

//--- tb/testbench.sv
// self-checking bench for the debug bus comparators
// assumes dbc_top, the cpu model and the bound checker
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int          LIMIT = 5000;
	localparam logic [17:0] HIT   = 18'h23456;
	logic                  aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic                  s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic                  session_end, trace_stop, break_req, armed, irq;
	logic [9:0]            s_axi_awaddr, s_axi_araddr;
	logic [2:0]            s_axi_awprot, s_axi_arprot, match_pulse;
	logic [31:0]           s_axi_wdata, s_axi_rdata;
	logic [3:0]            s_axi_wstrb;
	logic [1:0]            s_axi_bresp, s_axi_rresp;
	dbc_pkg::dbc_cpu_bus_t cpu_bus;
	dbc_pkg::dbc_exec_t    cpu_exec;
	logic [15:0]           tbl [12];
	int                    miscompares = 0, compares = 0, cycles = 0;
	dbc_top dut (.*);
	dbc_cpu_model cpu (.aclk, .cpu_bus, .cpu_exec);
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			miscompares++;
			end_of_test;
		end
	end
	task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %0h seen %0h", n, e, g);
		end
	endtask
	// a spare edge first, so no strobe is driven twice in one step
	task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er = dbc_pkg::RESP_OK);
		logic a, w, b;
		logic [1:0] p;
		a = 1'b1;
		w = 1'b1;
		b = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (a | w | !b) begin
			@(negedge aclk);
			a = a & !s_axi_awready;
			w = w & !s_axi_wready;
			b = s_axi_bvalid;
			p = s_axi_bresp;
			@(posedge aclk);
			s_axi_awvalid <= a;
			s_axi_wvalid <= w;
		end
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, p}, {30'h0, er});
	endtask
	task automatic rc(input logic [7:0] i, input logic [31:0] e, input logic [1:0] er = dbc_pkg::RESP_OK);
		logic a, r;
		logic [31:0] d;
		logic [1:0] p;
		a = 1'b1;
		r = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= {i, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (a | !r) begin
			@(negedge aclk);
			a = a & !s_axi_arready;
			r = s_axi_rvalid;
			d = s_axi_rdata;
			p = s_axi_rresp;
			@(posedge aclk);
			s_axi_arvalid <= a;
		end
		s_axi_rready <= 1'b0;
		chk("rdata", d, e);
		chk("rresp", {30'h0, p}, {30'h0, er});
	endtask
	task automatic pulse(input logic [17:0] a, input logic r, input logic s, input logic e);
		cpu.acc(a, r, s);
		@(negedge aclk);
		chk("match", match_pulse, {2'h0, e});
		@(negedge aclk);
		chk("match_after", match_pulse, 3'h0);
		@(posedge aclk);
	endtask
	task automatic end_of_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		{s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready, s_axi_araddr,
			s_axi_arprot, s_axi_arvalid, s_axi_rready, aresetn} = '0;
		s_axi_wstrb = 4'hF;
		// control, then flags: miss, read, byte, expected match
		tbl = '{16'h0101, 16'h0000, 16'h0108, 16'h0501, 16'h0504, 16'h0D05, 16'h0D00, 16'h8102, 16'h4103,
			16'hC103, 16'hC100, 16'h0300};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			wr(dbc_pkg::IDX_MAIN, 8'(k));
			rc(dbc_pkg::IDX_CTL, 32'h0);
			wr(dbc_pkg::IDX_CTL, 8'hFF);
			wr(dbc_pkg::IDX_AH, 8'hFF);
			wr(dbc_pkg::IDX_AM, 8'h10 + 8'(k));
			wr(dbc_pkg::IDX_DH, 8'h5A);
			rc(dbc_pkg::IDX_CTL, dbc_pkg::CTL_MASK[k]);
			rc(dbc_pkg::IDX_AH, 32'h3);
			rc(dbc_pkg::IDX_DH, k == 0 ? 32'h5A : 32'h0);
			wr(dbc_pkg::IDX_CTL, 8'h00);
		end
		for (int k = 0; k < 4; k++) begin
			wr(dbc_pkg::IDX_MAIN, 8'(k));
			rc(dbc_pkg::IDX_AM, k == 3 ? 32'h0 : 32'h10 + k);
		end
		rc(8'h3F, 32'h0, dbc_pkg::RESP_ERR);
		wr(8'h3F, 8'h00, dbc_pkg::RESP_ERR);
		$display("test window done");
		wr(dbc_pkg::IDX_MAIN, 8'h00);
		wr(dbc_pkg::IDX_AH, 8'h02);
		wr(dbc_pkg::IDX_AM, 8'h34);
		wr(dbc_pkg::IDX_AL, 8'h56);
		rc(dbc_pkg::IDX_AL, 32'h56);
		wr(dbc_pkg::IDX_MAIN, 8'h80);
		wr(dbc_pkg::IDX_AL, 8'h77);
		rc(dbc_pkg::IDX_AL, 32'h56);
		$display("test arm lock done");
		wr(dbc_pkg::IDX_MAIN, 8'h00);
		wr(dbc_pkg::IDX_CTL, 8'h01);
		pulse(HIT, 1'b0, 1'b0, 1'b0);
		foreach (tbl[n]) begin
			wr(dbc_pkg::IDX_MAIN, 8'h00);
			wr(dbc_pkg::IDX_CTL, tbl[n][15:8]);
			wr(dbc_pkg::IDX_MAIN, 8'h80);
			pulse(HIT ^ {17'h0, tbl[n][3]}, tbl[n][2], tbl[n][1], tbl[n][0]);
		end
		wr(dbc_pkg::IDX_MAIN, 8'h00);
		wr(dbc_pkg::IDX_MH, 8'hFF);
		wr(dbc_pkg::IDX_ML, 8'hFF);
		wr(dbc_pkg::IDX_DH, 8'hA5);
		wr(dbc_pkg::IDX_DL, 8'hC2);
		rc(dbc_pkg::IDX_ML, 32'hFF);
		wr(dbc_pkg::IDX_CTL, 8'h01);
		wr(dbc_pkg::IDX_MAIN, 8'h80);
		pulse(HIT, 1'b0, 1'b0, 1'b0);
		wr(dbc_pkg::IDX_MAIN, 8'h00);
		wr(dbc_pkg::IDX_CTL, 8'h03);
		wr(dbc_pkg::IDX_MAIN, 8'h80);
		pulse(HIT, 1'b0, 1'b0, 1'b1);
		wr(dbc_pkg::IDX_MAIN, 8'h00);
		wr(dbc_pkg::IDX_CTL, 8'h2D);
		wr(dbc_pkg::IDX_MAIN, 8'h80);
		pulse(HIT, 1'b0, 1'b0, 1'b0);
		cpu.ex(HIT);
		@(negedge aclk);
		chk("tag_fire", match_pulse, 3'h1);
		$display("test match done");
		wr(dbc_pkg::IDX_MAIN, 8'h00);
		wr(dbc_pkg::IDX_DL, 8'hC3);
		wr(dbc_pkg::IDX_CTL, 8'h11);
		wr(dbc_pkg::IDX_IEN, 8'h01);
		wr(dbc_pkg::IDX_ICLR, 8'h0F);
		wr(dbc_pkg::IDX_MAIN, 8'h90);
		cpu.acc(HIT, 1'b0, 1'b0);
		@(negedge aclk);
		chk("stop", {break_req, session_end, trace_stop, armed, irq}, 5'h1D);
		rc(dbc_pkg::IDX_STS, 32'h9);
		wr(dbc_pkg::IDX_IEN, 8'h00);
		@(negedge aclk);
		chk("irq_masked", irq, 1'b0);
		wr(dbc_pkg::IDX_IEN, 8'h01);
		wr(dbc_pkg::IDX_ICLR, 8'h0F);
		@(negedge aclk);
		chk("irq_cleared", irq, 1'b0);
		rc(dbc_pkg::IDX_STS, 32'h0);
		$display("test stop done");
		end_of_test;
	end
endmodule
